// >>> verilog/dct_pkg.sv
package dct_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // widths

    localparam int DCT_DATA_W  = 32;
    localparam int DCT_IDX_W   = 4;
    localparam int DCT_ADDR_W  = 8;
    localparam int DCT_BE_W    = 4;
    localparam int DCT_IDX_LSB = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses)

    localparam logic [DCT_ADDR_W-1:0] DCT_OFS_CTRL     = 8'h00;
    localparam logic [DCT_ADDR_W-1:0] DCT_OFS_STATUS   = 8'h04;
    localparam logic [DCT_ADDR_W-1:0] DCT_OFS_ENTRY_24 = 8'he0;
    localparam logic [DCT_ADDR_W-1:0] DCT_OFS_ENTRY_25 = 8'he4;
    localparam logic [DCT_ADDR_W-1:0] DCT_OFS_ENTRY_26 = 8'he8;
    localparam logic [DCT_ADDR_W-1:0] DCT_OFS_ENTRY_27 = 8'hec;

    ////////////////////////////////////////////////////////////////////////////////
    // fixed patterns of the table entries, index field cleared

    localparam logic [DCT_DATA_W-1:0] DCT_BASE_ENTRY_24 = 32'h0000_0000;
    localparam logic [DCT_DATA_W-1:0] DCT_BASE_ENTRY_25 = 32'h0000_2000;
    localparam logic [DCT_DATA_W-1:0] DCT_BASE_ENTRY_26 = 32'h0002_e000;
    localparam logic [DCT_DATA_W-1:0] DCT_BASE_ENTRY_27 = 32'h0003_2000;
    localparam logic [DCT_DATA_W-1:0] DCT_ZERO_WORD     = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // control and status fields

    localparam int DCT_CTRL_ERR_EN_BIT  = 0;
    localparam int DCT_STAT_CORE_EN_BIT = 0;
    localparam int DCT_STAT_WR_ERR_BIT  = 1;
    localparam int DCT_STAT_DEC_ERR_BIT = 2;
    localparam int DCT_LANE_LOW         = 0;

    localparam logic DCT_CTRL_ERR_EN_RST = 1'b0;
    localparam logic DCT_FLAG_RST        = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // avalon response codes

    localparam logic [1:0] DCT_RESP_OKAY    = 2'h0;
    localparam logic [1:0] DCT_RESP_SLVERR  = 2'h2;
    localparam logic [1:0] DCT_RESP_DECERR  = 2'h3;

    typedef enum logic {
        DCT_ST_IDLE,
        DCT_ST_ACK
    } dct_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // entry word: fixed pattern with the block index in bits 11:8

    function automatic logic [DCT_DATA_W-1:0] dct_entry_word(
        input logic [DCT_DATA_W-1:0] base,
        input logic [DCT_IDX_W-1:0]  idx
    );
        logic [DCT_DATA_W-1:0] w;
        w = base;
        w[DCT_IDX_LSB +: DCT_IDX_W] = idx;
        return w;
    endfunction

endpackage

// >>> verilog/dct_entry_view.sv
`timescale 1ns/1ps

module dct_entry_view
    import dct_pkg::*;
(
    input  wire logic [DCT_ADDR_W-1:0] addr_i,
    input  wire logic [DCT_IDX_W-1:0]  sel_24_i,
    input  wire logic [DCT_IDX_W-1:0]  sel_25_i,
    input  wire logic [DCT_IDX_W-1:0]  sel_26_i,
    input  wire logic [DCT_IDX_W-1:0]  sel_27_i,
    output logic                       hit_o,
    output logic [DCT_DATA_W-1:0]      word_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // live view of the table entries, no state and no side effect

    always_comb
    begin
        hit_o  = 1'b1;
        word_o = DCT_ZERO_WORD;
        case (addr_i)
            DCT_OFS_ENTRY_24: word_o = dct_entry_word(DCT_BASE_ENTRY_24, sel_24_i);
            DCT_OFS_ENTRY_25: word_o = dct_entry_word(DCT_BASE_ENTRY_25, sel_25_i);
            DCT_OFS_ENTRY_26: word_o = dct_entry_word(DCT_BASE_ENTRY_26, sel_26_i);
            DCT_OFS_ENTRY_27: word_o = dct_entry_word(DCT_BASE_ENTRY_27, sel_27_i);
            default:
            begin
                hit_o  = 1'b0;
                word_o = DCT_ZERO_WORD;
            end
        endcase
    end

endmodule

// >>> verilog/dct_top.sv
`timescale 1ns/1ps

// Function
// - reading an entry returns its live 32-bit table content, touching nothing in the core
// - entries stay readable regardless of whether the core is enabled
// - entry 24 is zero except block select 24 in bits 11:8
// - entry 25 holds 2 in bits 15:12, block select 25 in bits 11:8
// - entry 26 holds 2E in bits 19:12, block select 26 in bits 11:8
// - entries 24..26 are read-only words at e0, e4, e8; writes set the sticky write error flag and, with err_en set, answer SLVERR
// - entry 27 is a read-only word at ec
// - entry 27 holds 32 in bits 19:12, block select 27 in bits 11:8
module dct_top
    import dct_pkg::*;
#(
    parameter int ADDR_W = DCT_ADDR_W
)
(
    input  wire logic                  CORE_CLK_I,
    input  wire logic                  SYS_RST_I,
    input  wire logic [ADDR_W-1:0]     AVS_ADDRESS_I,
    input  wire logic                  AVS_READ_I,
    input  wire logic                  AVS_WRITE_I,
    input  wire logic [DCT_DATA_W-1:0] AVS_WRITEDATA_I,
    input  wire logic [DCT_BE_W-1:0]   AVS_BYTEENABLE_I,
    output logic      [DCT_DATA_W-1:0] AVS_READDATA_O,
    output logic      [1:0]            AVS_RESPONSE_O,
    output logic                       AVS_WAITREQUEST_O,
    input  wire logic [DCT_IDX_W-1:0]  BLOCK_SELECT_ENTRY_24_I,
    input  wire logic [DCT_IDX_W-1:0]  BLOCK_SELECT_ENTRY_25_I,
    input  wire logic [DCT_IDX_W-1:0]  BLOCK_SELECT_ENTRY_26_I,
    input  wire logic [DCT_IDX_W-1:0]  BLOCK_SELECT_ENTRY_27_I,
    input  wire logic                  CORE_ENABLED_I
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration check

    generate
        if (ADDR_W < DCT_ADDR_W)
        begin : g_bad_addr_w
            $error("address width too small for the register map");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        dct_state_t            state;
        logic [DCT_DATA_W-1:0] rdata;
        logic [1:0]            resp;
        logic                  err_en;
        logic                  wr_err;
        logic                  dec_err;
    } dct_regs_t;

    localparam dct_regs_t DCT_REGS_RST = '{
        state:   DCT_ST_IDLE,
        rdata:   DCT_ZERO_WORD,
        resp:    DCT_RESP_OKAY,
        err_en:  DCT_CTRL_ERR_EN_RST,
        wr_err:  DCT_FLAG_RST,
        dec_err: DCT_FLAG_RST
    };

    dct_regs_t             cur_ff;
    dct_regs_t             nxt_cur;

    logic [DCT_ADDR_W-1:0] low_addr;
    logic                  high_zero;
    logic                  entry_hit;
    logic [DCT_DATA_W-1:0] entry_word;
    logic                  req;
    logic                  set_wr_err;
    logic                  set_dec_err;
    logic                  clr_wr_err;
    logic                  clr_dec_err;
    logic [DCT_DATA_W-1:0] status_word;
    logic [DCT_DATA_W-1:0] ctrl_word;

    ////////////////////////////////////////////////////////////////////////////////
    // address split, upper address bits must be zero for a hit

    assign low_addr  = AVS_ADDRESS_I[DCT_ADDR_W-1:0];
    assign high_zero = (AVS_ADDRESS_I >> DCT_ADDR_W) == '0;
    assign req       = AVS_READ_I | AVS_WRITE_I;

    ////////////////////////////////////////////////////////////////////////////////
    // entry view

    logic                  view_hit;

    dct_entry_view u_view (
        .addr_i   (low_addr),
        .sel_24_i (BLOCK_SELECT_ENTRY_24_I),
        .sel_25_i (BLOCK_SELECT_ENTRY_25_I),
        .sel_26_i (BLOCK_SELECT_ENTRY_26_I),
        .sel_27_i (BLOCK_SELECT_ENTRY_27_I),
        .hit_o    (view_hit),
        .word_o   (entry_word)
    );

    assign entry_hit = view_hit & high_zero;

    ////////////////////////////////////////////////////////////////////////////////
    // readback words of the local registers

    always_comb
    begin
        ctrl_word                        = DCT_ZERO_WORD;
        ctrl_word[DCT_CTRL_ERR_EN_BIT]   = cur_ff.err_en;
        status_word                      = DCT_ZERO_WORD;
        status_word[DCT_STAT_CORE_EN_BIT] = CORE_ENABLED_I;
        status_word[DCT_STAT_WR_ERR_BIT]  = cur_ff.wr_err;
        status_word[DCT_STAT_DEC_ERR_BIT] = cur_ff.dec_err;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave: take request in idle, answer with waitrequest low one cycle later

    always_comb
    begin
        nxt_cur     = cur_ff;
        set_wr_err  = 1'b0;
        set_dec_err = 1'b0;
        clr_wr_err  = 1'b0;
        clr_dec_err = 1'b0;
        case (cur_ff.state)
            DCT_ST_IDLE:
            begin
                if (req)
                begin
                    nxt_cur.state = DCT_ST_ACK;
                    nxt_cur.resp  = DCT_RESP_OKAY;
                    nxt_cur.rdata = DCT_ZERO_WORD;
                    if (AVS_READ_I)
                    begin
                        if (entry_hit)
                        begin
                            // no core enable gating
                            nxt_cur.rdata = entry_word;
                        end
                        else if (high_zero && low_addr == DCT_OFS_CTRL)
                        begin
                            nxt_cur.rdata = ctrl_word;
                        end
                        else if (high_zero && low_addr == DCT_OFS_STATUS)
                        begin
                            nxt_cur.rdata = status_word;
                        end
                        else
                        begin
                            set_dec_err = 1'b1;
                            if (cur_ff.err_en)
                            begin
                                nxt_cur.resp = DCT_RESP_DECERR;
                            end
                        end
                    end
                    else
                    begin
                        if (entry_hit)
                        begin
                            // write to a read-only entry is dropped
                            set_wr_err = 1'b1;
                            if (cur_ff.err_en)
                            begin
                                nxt_cur.resp = DCT_RESP_SLVERR;
                            end
                        end
                        else if (high_zero && low_addr == DCT_OFS_CTRL)
                        begin
                            if (AVS_BYTEENABLE_I[DCT_LANE_LOW])
                            begin
                                nxt_cur.err_en = AVS_WRITEDATA_I[DCT_CTRL_ERR_EN_BIT];
                            end
                        end
                        else if (high_zero && low_addr == DCT_OFS_STATUS)
                        begin
                            if (AVS_BYTEENABLE_I[DCT_LANE_LOW])
                            begin
                                clr_wr_err  = AVS_WRITEDATA_I[DCT_STAT_WR_ERR_BIT];
                                clr_dec_err = AVS_WRITEDATA_I[DCT_STAT_DEC_ERR_BIT];
                            end
                        end
                        else
                        begin
                            set_dec_err = 1'b1;
                            if (cur_ff.err_en)
                            begin
                                nxt_cur.resp = DCT_RESP_DECERR;
                            end
                        end
                    end
                end
            end
            DCT_ST_ACK:
            begin
                nxt_cur.state = DCT_ST_IDLE;
            end
            default:
            begin
                nxt_cur.state = DCT_ST_IDLE;
            end
        endcase
        // sticky flags, a set in the clearing cycle wins
        nxt_cur.wr_err  = (cur_ff.wr_err & ~clr_wr_err) | set_wr_err;
        nxt_cur.dec_err = (cur_ff.dec_err & ~clr_dec_err) | set_dec_err;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SYS_RST_I)
        begin
            cur_ff <= DCT_REGS_RST;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign AVS_WAITREQUEST_O = (cur_ff.state != DCT_ST_ACK);
    assign AVS_READDATA_O    = cur_ff.rdata;
    assign AVS_RESPONSE_O    = cur_ff.resp;

endmodule

// >>> test/dct_top_properties.sv
`timescale 1ns/1ps

module dct_top_properties
    import dct_pkg::*;
#(
    parameter int ADDR_W = DCT_ADDR_W
)
(
    input wire logic                  CORE_CLK_I,
    input wire logic                  SYS_RST_I,
    input wire logic [ADDR_W-1:0]     AVS_ADDRESS_I,
    input wire logic                  AVS_READ_I,
    input wire logic                  AVS_WRITE_I,
    input wire logic [DCT_DATA_W-1:0] AVS_READDATA_O,
    input wire logic [1:0]            AVS_RESPONSE_O,
    input wire logic                  AVS_WAITREQUEST_O,
    input wire logic [DCT_IDX_W-1:0]  BLOCK_SELECT_ENTRY_24_I,
    input wire logic [DCT_IDX_W-1:0]  BLOCK_SELECT_ENTRY_25_I,
    input wire logic [DCT_IDX_W-1:0]  BLOCK_SELECT_ENTRY_26_I,
    input wire logic [DCT_IDX_W-1:0]  BLOCK_SELECT_ENTRY_27_I,
    input wire logic                  CORE_ENABLED_I
);
    ////////////////////////////////////////////////////////////////////////////////
    // request taken, entry address hit
    logic rd_tk;
    logic wr_tk;
    logic ent;
    assign rd_tk = AVS_READ_I && AVS_WAITREQUEST_O && !SYS_RST_I;
    assign wr_tk = AVS_WRITE_I && AVS_WAITREQUEST_O && !SYS_RST_I;
    assign ent   = AVS_ADDRESS_I[ADDR_W-1:4] == (ADDR_W-4)'(8'h0e) && AVS_ADDRESS_I[1:0] == 2'h0;

    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    ////////////////////////////////////////////////////////////////////////////////
    a_entry24_word: assert property (rd_tk && AVS_ADDRESS_I == ADDR_W'(DCT_OFS_ENTRY_24)
        |=> AVS_READDATA_O == {20'h0, $past(BLOCK_SELECT_ENTRY_24_I), 8'h00}) else $error("entry 24 word wrong");
    a_entry25_word: assert property (rd_tk && AVS_ADDRESS_I == ADDR_W'(DCT_OFS_ENTRY_25)
        |=> AVS_READDATA_O == {16'h0, 4'h2, $past(BLOCK_SELECT_ENTRY_25_I), 8'h00}) else $error("entry 25 word wrong");
    a_entry26_word: assert property (rd_tk && AVS_ADDRESS_I == ADDR_W'(DCT_OFS_ENTRY_26)
        |=> AVS_READDATA_O == {12'h0, 8'h2e, $past(BLOCK_SELECT_ENTRY_26_I), 8'h00}) else $error("entry 26 word wrong");
    a_entry27_word: assert property (rd_tk && AVS_ADDRESS_I == ADDR_W'(DCT_OFS_ENTRY_27)
        |=> AVS_READDATA_O == {12'h0, 8'h32, $past(BLOCK_SELECT_ENTRY_27_I), 8'h00}) else $error("entry 27 word wrong");
    a_read_one_wait: assert property (rd_tk && ent
        |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O) else $error("entry read not answered in one cycle");
    a_idle_core_read: assert property (rd_tk && ent && !CORE_ENABLED_I
        |=> !AVS_WAITREQUEST_O && AVS_RESPONSE_O == DCT_RESP_OKAY) else $error("read refused with core off");
    a_ro_write_zero: assert property (wr_tk && ent
        |=> !AVS_WAITREQUEST_O && AVS_READDATA_O == 32'h0) else $error("entry write answer not zero");
    a_ec_read_ok: assert property (rd_tk && AVS_ADDRESS_I == ADDR_W'(DCT_OFS_ENTRY_27)
        |=> !AVS_WAITREQUEST_O && AVS_RESPONSE_O == DCT_RESP_OKAY) else $error("entry 27 read not okay");
endmodule

bind dct_top dct_top_properties #(.ADDR_W(ADDR_W)) props_u (.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_RESPONSE_O(AVS_RESPONSE_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .BLOCK_SELECT_ENTRY_24_I(BLOCK_SELECT_ENTRY_24_I), .BLOCK_SELECT_ENTRY_25_I(BLOCK_SELECT_ENTRY_25_I),
    .BLOCK_SELECT_ENTRY_26_I(BLOCK_SELECT_ENTRY_26_I), .BLOCK_SELECT_ENTRY_27_I(BLOCK_SELECT_ENTRY_27_I),
    .CORE_ENABLED_I(CORE_ENABLED_I));

// >>> test/dct_top_tb.sv
`timescale 1ns/1ps

module dct_top_tb;
    logic        clk     = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  addr    = 8'h00;
    logic        rd      = 1'b0;
    logic        wr      = 1'b0;
    logic [31:0] wdat    = 32'h0;
    logic        core_en = 1'b0;
    logic [3:0]  sel [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
    logic [31:0] base [4] = '{32'h0, 32'h2000, 32'h2e000, 32'h32000};
    logic [31:0] rdat;
    logic [1:0]  resp;
    logic        waitreq;
    logic [31:0] got;
    logic [1:0]  gresp;
    int          n_fail     = 0;
    int          num_checks = 0;

    always #50 clk = ~clk;

    dct_top dut_u (.CORE_CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdat), .AVS_RESPONSE_O(resp),
        .AVS_WAITREQUEST_O(waitreq), .BLOCK_SELECT_ENTRY_24_I(sel[0]), .BLOCK_SELECT_ENTRY_25_I(sel[1]),
        .BLOCK_SELECT_ENTRY_26_I(sel[2]), .BLOCK_SELECT_ENTRY_27_I(sel[3]), .CORE_ENABLED_I(core_en));

    ////////////////////////////////////////////////////////////////////////////////
    // report and compare
    task automatic give_verdict();
        if (n_fail == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %0t word got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %0t resp got %h exp %h", $time, g, e);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // one bus transfer, held until waitrequest low
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        rd   <= !w;
        wr   <= w;
        addr <= a;
        wdat <= d;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (waitreq === 1'b0)
                break;
        end
        if (n == 20)
        begin
            n_fail++;
            give_verdict();
        end
        else
        begin
            got   = rdat;
            gresp = resp;
            rd    <= 1'b0;
            wr    <= 1'b0;
            @(posedge clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic sc_entries();
        for (int e = 0; e < 4; e++)
            for (int s = 0; s < 16; s += 5)
            begin
                @(posedge clk);
                for (int k = 0; k < 4; k++)
                    sel[k] <= 4'(s + 3 * k);
                core_en <= s[0];
                xfer(1'b0, 8'he0 + 8'(4 * e), 32'h0);
                chk_word(got, base[e] | {20'h0, 4'(s + 3 * e), 8'h00});
                chk_resp(gresp, 2'h0);
            end
    endtask

    task automatic sc_write_ro();
        xfer(1'b1, 8'h00, 32'h1);
        for (int e = 0; e < 4; e++)
        begin
            xfer(1'b1, 8'he0 + 8'(4 * e), 32'hffff_ffff);
            chk_resp(gresp, 2'h2);
            chk_word(got, 32'h0);
            xfer(1'b0, 8'he0 + 8'(4 * e), 32'h0);
            chk_word(got, base[e] | {20'h0, sel[e], 8'h00});
        end
        xfer(1'b0, 8'h04, 32'h0);
        chk_word(got, {29'h0, 2'h1, core_en});
    endtask

    task automatic sc_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        xfer(1'b0, 8'h00, 32'h0);
        chk_word(got, 32'h0);
        xfer(1'b0, 8'h04, 32'h0);
        chk_word(got, {29'h0, 2'h0, core_en});
    endtask

    task automatic sc_unmapped();
        xfer(1'b1, 8'h00, 32'h1);
        xfer(1'b0, 8'h10, 32'h0);
        chk_word(got, 32'h0);
        chk_resp(gresp, 2'h3);
        xfer(1'b0, 8'he2, 32'h0);
        chk_resp(gresp, 2'h3);
        xfer(1'b1, 8'h00, 32'h0);
        xfer(1'b0, 8'h10, 32'h0);
        chk_resp(gresp, 2'h0);
        xfer(1'b0, 8'h04, 32'h0);
        chk_word(got, {29'h0, 2'h2, core_en});
        xfer(1'b1, 8'h04, 32'h6);
        xfer(1'b0, 8'h04, 32'h0);
        chk_word(got, {29'h0, 2'h0, core_en});
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        sc_entries();
        sc_write_ro();
        sc_reset();
        sc_unmapped();
        give_verdict();
    end
endmodule
